/* File: sbg_pkg.sv */
// sbg_pkg: constants, state encodings and state records of the baud generator
// assumes a single core clock; every consumer refers to names as sbg_pkg::name
package sbg_pkg;

  localparam int SBG_PRE_W = 10;
  localparam int SBG_DIV_W = 16;
  localparam int SBG_LOW_MSB = 7;
  localparam int SBG_EDGE_W = 3;

  // base clock dividers of the core clock, and the measuring clock factor
  localparam logic [SBG_PRE_W-1:0] SBG_BASE_SLOW = 10'h040;
  localparam logic [SBG_PRE_W-1:0] SBG_BASE_MID = 10'h010;
  localparam logic [SBG_PRE_W-1:0] SBG_BASE_FAST = 10'h004;
  localparam logic [SBG_PRE_W-1:0] SBG_PRE_ONE = 10'h001;
  localparam logic [SBG_PRE_W-1:0] SBG_PRE_ZERO = 10'h000;
  localparam int SBG_ABD_SHIFT = 3;

  localparam logic [1:0] SBG_SEL_NONE = 2'h0;
  localparam logic [1:0] SBG_SEL_ONE = 2'h1;
  localparam logic [1:0] SBG_SEL_BOTH = 2'h2;

  localparam logic [SBG_DIV_W-1:0] SBG_DIV_ZERO = 16'h0000;
  localparam logic [SBG_DIV_W-1:0] SBG_DIV_ONE = 16'h0001;
  localparam logic [SBG_DIV_W-1:0] SBG_DIV_FULL = 16'hffff;
  localparam logic [7:0] SBG_ZERO_BYTE = 8'h00;

  localparam logic [SBG_EDGE_W-1:0] SBG_EDGE_ZERO = 3'h0;
  localparam logic [SBG_EDGE_W-1:0] SBG_EDGE_FIRST = 3'h1;
  localparam logic [SBG_EDGE_W-1:0] SBG_EDGE_STEP = 3'h1;
  localparam logic [SBG_EDGE_W-1:0] SBG_EDGE_LAST = 3'h4;

  typedef enum logic [3:0] {
    SBG_AB_IDLE = 4'b0001,
    SBG_AB_FALL = 4'b0010,
    SBG_AB_RISE = 4'b0100,
    SBG_AB_COUNT = 4'b1000
  } sbg_ab_state_type;

  typedef enum logic [2:0] {
    SBG_WK_IDLE = 3'b001,
    SBG_WK_FALL = 3'b010,
    SBG_WK_RISE = 3'b100
  } sbg_wk_state_type;

  // state of the line synchroniser
  typedef struct packed {
    logic [2:0] stage;
    logic level;
    logic rise;
    logic fall;
  } sbg_sync_type;

  // state of the generator
  typedef struct packed {
    sbg_ab_state_type ab;
    sbg_wk_state_type wk;
    logic [SBG_PRE_W-1:0] pre;
    logic [SBG_DIV_W-1:0] timer;
    logic [SBG_DIV_W-1:0] divisor;
    logic [SBG_EDGE_W-1:0] edges;
    logic ab_en;
    logic ovf;
    logic wakeup_enable;
    logic rif;
    logic idle;
    logic tick;
    logic hold;
    logic wake_evt;
  } sbg_state_type;

  // line events handed from the synchroniser
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } sbg_line_type;

endpackage : sbg_pkg

/* File: sbg_line_sync.sv */
// sbg_line_sync: three-stage synchroniser of the receive line with edge pulses
// assumes the line is asynchronous to mclk_i; idles high like a serial line
`timescale 1ns/1ns
module sbg_line_sync (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic receive_line_i,
  output sbg_pkg::sbg_line_type line_o
);

  sbg_pkg::sbg_sync_type st;
  sbg_pkg::sbg_sync_type next_st;

  // a change is taken only once the second and third stages agree
  always_comb
  begin
    next_st = st;
    next_st.stage = {st.stage[1:0], receive_line_i};
    next_st.rise = 1'b0;
    next_st.fall = 1'b0;
    if (st.stage[1] == st.stage[2] && st.stage[2] != st.level)
    begin
      next_st.level = st.stage[2];
      next_st.rise = st.stage[2];
      next_st.fall = ~st.stage[2];
    end
  end

  // reset to the idle-high line so no false edge follows reset
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st <= '{stage: 3'h7, level: 1'b1, rise: 1'b0, fall: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign line_o = '{level: st.level, rise: st.rise, fall: st.fall};

endmodule : sbg_line_sync

/* File: sbg_baud_gen.sv */
// sbg_baud_gen: baud-rate timer with auto-baud measurement and wake-up on break
// assumes control strobes come from core logic on mclk_i, the line from a pin
`timescale 1ns/1ns
module sbg_baud_gen (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic port_enable_i,
  input wire logic sync_mode_i,
  input wire logic sleep_i,
  input wire logic wide_divisor_select_i,
  input wire logic high_speed_select_i,
  input wire logic divisor_write_i,
  input wire logic [7:0] divisor_high_byte_i,
  input wire logic [7:0] divisor_low_byte_i,
  input wire logic autobaud_set_i,
  input wire logic autobaud_clear_i,
  input wire logic overflow_clear_i,
  input wire logic wakeup_set_i,
  input wire logic wakeup_clear_i,
  input wire logic receive_data_read_i,
  input wire logic receive_line_i,
  output logic [15:0] divisor_pair_o,
  output logic baud_tick_o,
  output logic autobaud_enable_o,
  output logic autobaud_overflow_flag_o,
  output logic wakeup_enable_o,
  output logic receive_interrupt_flag_o,
  output logic receive_idle_status_o,
  output logic receiver_hold_o,
  output logic wake_event_o
);

  sbg_pkg::sbg_state_type st;
  sbg_pkg::sbg_state_type next_st;
  sbg_pkg::sbg_line_type line;
  logic hs_eff;
  logic [1:0] nsel;
  logic [sbg_pkg::SBG_PRE_W-1:0] base_div;
  logic [sbg_pkg::SBG_PRE_W-1:0] pre_lim;
  logic pre_hit;
  logic [sbg_pkg::SBG_DIV_W-1:0] top;
  logic measuring;
  logic ab_done;
  logic ab_wrap;
  logic wake_fall;
  logic break_end;

  sbg_line_sync u_sync (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .receive_line_i(receive_line_i),
    .line_o(line)
  );

  // clock selection: high speed select counts only in asynchronous mode
  always_comb
  begin
    hs_eff = high_speed_select_i & ~sync_mode_i;
    nsel = {1'b0, wide_divisor_select_i} + {1'b0, hs_eff};
    unique case (nsel)
      sbg_pkg::SBG_SEL_NONE: base_div = sbg_pkg::SBG_BASE_SLOW;
      sbg_pkg::SBG_SEL_ONE: base_div = sbg_pkg::SBG_BASE_MID;
      default: base_div = sbg_pkg::SBG_BASE_FAST;
    endcase
    measuring = (st.ab == sbg_pkg::SBG_AB_COUNT);
    // measuring clock is the base clock slowed eightfold
    pre_lim = measuring ? (base_div << sbg_pkg::SBG_ABD_SHIFT) : base_div;
    // at or past the limit counts as a hit, so a smaller divider chosen mid-count
    // restarts the prescaler instead of letting it run round its full range
    pre_hit = (st.pre >= pre_lim - sbg_pkg::SBG_PRE_ONE) && !sleep_i;
    // narrow mode compares against the low byte only
    top = wide_divisor_select_i ? st.divisor :
      {sbg_pkg::SBG_ZERO_BYTE, st.divisor[sbg_pkg::SBG_LOW_MSB:0]};
  end

  // event terms shared by the flag logic and the checks below
  always_comb
  begin
    ab_done = measuring && line.rise && st.edges == sbg_pkg::SBG_EDGE_LAST;
    ab_wrap = measuring && pre_hit && st.divisor == sbg_pkg::SBG_DIV_FULL;
    wake_fall = (st.wk == sbg_pkg::SBG_WK_FALL) && line.fall;
    break_end = (st.wk == sbg_pkg::SBG_WK_RISE) && line.rise;
  end

  // next state of the whole generator
  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    next_st.wake_evt = 1'b0;
    // prescaler: frozen in sleep, restarted when a new divisor lands
    if (!sleep_i)
    begin
      next_st.pre = pre_hit ? sbg_pkg::SBG_PRE_ZERO : st.pre + sbg_pkg::SBG_PRE_ONE;
    end
    // free-running timer; stays cleared while the line times the counter
    if (measuring || st.ab != sbg_pkg::SBG_AB_IDLE)
    begin
      next_st.timer = sbg_pkg::SBG_DIV_ZERO;
    end
    else if (pre_hit)
    begin
      if (st.timer >= top)
      begin
        next_st.timer = sbg_pkg::SBG_DIV_ZERO;
        next_st.tick = 1'b1;
      end
      else
      begin
        next_st.timer = st.timer + sbg_pkg::SBG_DIV_ONE;
      end
    end
    // a write during measurement would corrupt the count, so it is dropped
    if (divisor_write_i && st.ab == sbg_pkg::SBG_AB_IDLE)
    begin
      next_st.divisor = {divisor_high_byte_i, divisor_low_byte_i};
      next_st.timer = sbg_pkg::SBG_DIV_ZERO;
      next_st.pre = sbg_pkg::SBG_PRE_ZERO;
    end
    // auto-baud enable: a fresh set wins over completion or abort
    next_st.ab_en = (st.ab_en & ~autobaud_clear_i & ~ab_done) | autobaud_set_i;
    // wake enable arms in asynchronous mode only
    next_st.wakeup_enable = (st.wakeup_enable & ~wakeup_clear_i & ~break_end) |
      (wakeup_set_i & ~sync_mode_i);
    // measurement sequencer
    unique case (st.ab)
      sbg_pkg::SBG_AB_IDLE:
      begin
        // with wake enabled the break passes first, then the sync byte
        if (st.ab_en && !st.wakeup_enable && !sleep_i)
        begin
          next_st.ab = sbg_pkg::SBG_AB_FALL;
        end
      end
      sbg_pkg::SBG_AB_FALL:
      begin
        if (line.fall)
        begin
          next_st.ab = sbg_pkg::SBG_AB_RISE;
        end
      end
      sbg_pkg::SBG_AB_RISE:
      begin
        if (line.rise)
        begin
          next_st.ab = sbg_pkg::SBG_AB_COUNT;
          next_st.divisor = sbg_pkg::SBG_DIV_ONE;
          next_st.edges = sbg_pkg::SBG_EDGE_FIRST;
          next_st.pre = sbg_pkg::SBG_PRE_ZERO;
        end
      end
      sbg_pkg::SBG_AB_COUNT:
      begin
        if (pre_hit)
        begin
          next_st.divisor = st.divisor + sbg_pkg::SBG_DIV_ONE;
        end
        if (line.rise)
        begin
          next_st.edges = st.edges + sbg_pkg::SBG_EDGE_STEP;
        end
        if (ab_done)
        begin
          next_st.ab = sbg_pkg::SBG_AB_IDLE;
          next_st.edges = sbg_pkg::SBG_EDGE_ZERO;
        end
      end
    endcase
    // an abort returns the sequencer to idle at once, whatever edges are still to come; an armed wake enable still holds the receiver
    if (autobaud_clear_i && !autobaud_set_i)
    begin
      next_st.ab = sbg_pkg::SBG_AB_IDLE;
      next_st.edges = sbg_pkg::SBG_EDGE_ZERO;
    end
    // wake watcher: falling edge is the event, the next rise ends the break
    unique case (st.wk)
      sbg_pkg::SBG_WK_IDLE:
      begin
        if (st.wakeup_enable)
        begin
          next_st.wk = sbg_pkg::SBG_WK_FALL;
        end
      end
      sbg_pkg::SBG_WK_FALL:
      begin
        if (!st.wakeup_enable)
        begin
          next_st.wk = sbg_pkg::SBG_WK_IDLE;
        end
        else if (line.fall)
        begin
          next_st.wk = sbg_pkg::SBG_WK_RISE;
          next_st.wake_evt = 1'b1;
        end
      end
      sbg_pkg::SBG_WK_RISE:
      begin
        if (!st.wakeup_enable || line.rise)
        begin
          next_st.wk = sbg_pkg::SBG_WK_IDLE;
        end
      end
    endcase
    // flags: a setting event in the clearing cycle is kept
    next_st.rif = wake_fall | ab_done | ab_wrap |
      (st.rif & ~receive_data_read_i);
    next_st.ovf = ab_wrap | (st.ovf & ~overflow_clear_i);
    next_st.idle = (next_st.ab == sbg_pkg::SBG_AB_IDLE);
    next_st.hold = (next_st.ab != sbg_pkg::SBG_AB_IDLE) | next_st.wakeup_enable;
  end

  // the disabled port is held in its reset state
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st <= '{ab: sbg_pkg::SBG_AB_IDLE, wk: sbg_pkg::SBG_WK_IDLE, pre: '0, timer: '0,
        divisor: '0, edges: '0, idle: 1'b1, default: 1'b0};
    end
    else if (!port_enable_i)
    begin
      st <= '{ab: sbg_pkg::SBG_AB_IDLE, wk: sbg_pkg::SBG_WK_IDLE, pre: '0, timer: '0,
        divisor: '0, edges: '0, idle: 1'b1, default: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  // every output is a flip-flop of the state record
  assign divisor_pair_o = st.divisor;
  assign baud_tick_o = st.tick;
  assign autobaud_enable_o = st.ab_en;
  assign autobaud_overflow_flag_o = st.ovf;
  assign wakeup_enable_o = st.wakeup_enable;
  assign receive_interrupt_flag_o = st.rif;
  assign receive_idle_status_o = st.idle;
  assign receiver_hold_o = st.hold;
  assign wake_event_o = st.wake_evt;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i || !port_enable_i);

  // prescaler restarts once it reaches the selected divider
  prescale_range_a: assert property (
    !sleep_i && st.pre >= pre_lim - sbg_pkg::SBG_PRE_ONE |=> st.pre == sbg_pkg::SBG_PRE_ZERO)
    else $error("prescaler ran past selected divider");

  // a divisor write leaves the timer cleared next cycle
  divisor_clear_a: assert property (
    divisor_write_i && st.ab == sbg_pkg::SBG_AB_IDLE |=> st.timer == sbg_pkg::SBG_DIV_ZERO)
    else $error("timer not cleared by divisor write");

  // a tick and a cleared timer follow once the timer reached its top
  tick_cause_a: assert property (
    !measuring && st.ab == sbg_pkg::SBG_AB_IDLE && pre_hit && st.timer >= top
    && !divisor_write_i |=> baud_tick_o && st.timer == sbg_pkg::SBG_DIV_ZERO)
    else $error("baud tick missing at timer top");

  // measurement starts at one on the first rise
  count_start_a: assert property (
    st.ab == sbg_pkg::SBG_AB_RISE && line.rise && !autobaud_clear_i
    |=> divisor_pair_o == sbg_pkg::SBG_DIV_ONE && !receive_idle_status_o)
    else $error("measurement did not start at one");

  // completion: enable drops, flag and idle rise together
  ab_done_a: assert property (
    ab_done && !autobaud_set_i && !autobaud_clear_i
    |=> !autobaud_enable_o && receive_interrupt_flag_o && receive_idle_status_o
    && divisor_pair_o == $past(st.divisor) +
    ($past(pre_hit) ? sbg_pkg::SBG_DIV_ONE : sbg_pkg::SBG_DIV_ZERO))
    else $error("auto-baud completion effects missing");

  // counter wrap raises both flags
  ab_wrap_a: assert property (
    ab_wrap |=> autobaud_overflow_flag_o && receive_interrupt_flag_o)
    else $error("overflow not flagged");

  // a wake event sets the receive flag and pulses the event
  wake_flag_a: assert property (
    wake_fall |=> receive_interrupt_flag_o && wake_event_o ##1 !wake_event_o)
    else $error("wake event did not set receive flag");

  // end of break clears wake enable
  break_end_a: assert property (
    break_end && !wakeup_set_i |=> !wakeup_enable_o)
    else $error("wake enable not cleared after break");

  // wake enable never arms in synchronous mode and holds the receiver
  wake_async_a: assert property (
    sync_mode_i && !wakeup_enable_o |=> !wakeup_enable_o)
    else $error("wake enable set in synchronous mode");

  wake_hold_a: assert property (wakeup_enable_o |-> receiver_hold_o)
    else $error("receiver not held while wake enabled");

  // abort returns the sequencer to idle and releases the receiver
  abort_a: assert property (
    autobaud_clear_i && !autobaud_set_i && !wakeup_enable_o && !wakeup_set_i
    |=> receive_idle_status_o && !receiver_hold_o)
    else $error("abort did not release receiver");

  // a data register read clears the receive flag when nothing sets it again
  read_clear_a: assert property (
    receive_interrupt_flag_o && receive_data_read_i && !wake_fall && !ab_done && !ab_wrap
    |=> !receive_interrupt_flag_o)
    else $error("receive flag not cleared by read");

  // idle status stays low while the count runs
  idle_low_a: assert property (
    measuring && !ab_done && !autobaud_clear_i |=> !receive_idle_status_o)
    else $error("idle status rose before fifth rise");

  // an armed enable leaves idle and holds the receiver
  measure_start_a: assert property (
    st.ab == sbg_pkg::SBG_AB_IDLE && st.ab_en && !st.wakeup_enable && !sleep_i && !autobaud_clear_i
    |=> !receive_idle_status_o && receiver_hold_o)
    else $error("measurement did not start");

  // the count steps on each slowed prescale hit, carrying through all 16 bits
  measure_step_a: assert property (
    measuring && pre_hit && !autobaud_clear_i
    |=> divisor_pair_o == $past(st.divisor) + sbg_pkg::SBG_DIV_ONE)
    else $error("measuring count did not step");

  // no baud tick is made while asleep
  sleep_pause_a: assert property (sleep_i |=> !baud_tick_o)
    else $error("baud tick during sleep");

  // a clear pulse disarms wake-up and frees the receiver
  wake_cancel_a: assert property (
    wakeup_clear_i && !wakeup_set_i && !autobaud_enable_o && st.ab == sbg_pkg::SBG_AB_IDLE
    |=> !wakeup_enable_o && !receiver_hold_o)
    else $error("wake enable not cleared");

endmodule : sbg_baud_gen

/* File: sbg_remote_node.sv */
// sbg_remote_node: remote sender on the receive line (break, sync and data characters)
// assumes bit times given in core clock cycles of 20 ns; the line idles high as on a pulled-up bus
`timescale 1ns/1ns
module sbg_remote_node (
  output logic line_o
);
  localparam int CYC_NS = 20;

  // idle level of a released serial line
  initial line_o = 1'b1;

  // start bit, eight data bits lsb first, stop bit; odd offset keeps edges off the core clock
  task send_byte(input int bit_cyc, input logic [7:0] data);
    int i;
    #7;
    line_o = 1'b0;
    #(bit_cyc * CYC_NS);
    for (i = 0; i < 8; i++)
    begin
      line_o = data[i];
      #(bit_cyc * CYC_NS);
    end
    line_o = 1'b1;
    #(bit_cyc * CYC_NS);
  endtask : send_byte

  // all-zero wake character, then idle time so a sleeping oscillator can start
  task send_break(input int bit_cyc, input int nbits);
    #7;
    line_o = 1'b0;
    #(nbits * bit_cyc * CYC_NS);
    line_o = 1'b1;
    #(2 * bit_cyc * CYC_NS);
  endtask : send_break
endmodule : sbg_remote_node

/* File: tb_top.sv */
// tb_top: self-checking bench of the baud generator with auto-baud and wake-up
// assumes sbg_baud_gen and sbg_remote_node are compiled; one 50 MHz core clock
`timescale 1ns/1ns
module tb_top;
  logic mclk_i, nrst_i, en, syncm, slp, wide, hs, tick, ab_en, ovf, wakeup_enable, rif, idle, hold, wev;
  logic line;
  logic [4:0] stb;
  logic [1:0] clr;
  logic [7:0] dhi, dlo;
  logic [15:0] div, gap;
  logic ab_prev;
  logic [15:0] exp_gap[$];
  logic [15:0] exp_div[$];
  integer seed;
  int err_count, num_checks, ticks, wakes, n, t0;

  sbg_remote_node node_u (.line_o(line));

  sbg_baud_gen dut_u (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .port_enable_i(en), .sync_mode_i(syncm),
    .sleep_i(slp), .wide_divisor_select_i(wide), .high_speed_select_i(hs),
    .divisor_write_i(stb[4]), .divisor_high_byte_i(dhi), .divisor_low_byte_i(dlo),
    .autobaud_set_i(stb[0]), .autobaud_clear_i(stb[1]), .overflow_clear_i(clr[0]),
    .wakeup_set_i(stb[2]), .wakeup_clear_i(clr[1]), .receive_data_read_i(stb[3]),
    .receive_line_i(line), .divisor_pair_o(div), .baud_tick_o(tick),
    .autobaud_enable_o(ab_en), .autobaud_overflow_flag_o(ovf), .wakeup_enable_o(wakeup_enable),
    .receive_interrupt_flag_o(rif), .receive_idle_status_o(idle), .receiver_hold_o(hold),
    .wake_event_o(wev)
  );

  // 50 MHz core clock
  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // base clock divider by how many selects count; high speed has no say in synchronous mode
  function automatic logic [15:0] base(input logic w, input logic h, input logic s);
    int k;
    k = int'(w) + int'(h && !s);
    return (k == 0) ? 16'h0040 : ((k == 1) ? 16'h0010 : 16'h0004);
  endfunction : base

  // one-cycle strobes, several at once when the mask says so
  task strobe(input logic [4:0] m);
    @(negedge mclk_i);
    stb = m;
    @(negedge mclk_i);
    stb = 5'h00;
  endtask : strobe

  task do_write(input logic [15:0] dv);
    {dhi, dlo} = dv;
    strobe(5'h10);
  endtask : do_write

  // bounded wait for the next tick; n counts core cycles
  task wait_tick;
    n = 0;
    do
    begin
      @(negedge mclk_i);
      n++;
    end while (tick !== 1'b1 && n < 5000);
  endtask : wait_tick

  task tick_case(input logic w, input logic h, input logic s, input logic [15:0] dv);
    logic [15:0] per;
    @(negedge mclk_i);
    wide = w;
    hs = h;
    syncm = s;
    per = base(w, h, s) * ((w ? dv : {8'h00, dv[7:0]}) + 16'h0001);
    do_write(dv);
    wait_tick();
    chk({15'h0000, n >= int'(per) - 2 && n <= int'(per) + 4}, 16'h0001, "first tick");
    // the watcher sees the first tick one edge later; its gap is no full period
    @(negedge mclk_i);
    exp_gap.push_back(per);
    exp_gap.push_back(per);
    wait_tick();
    wait_tick();
    @(negedge mclk_i);
    chk(16'(exp_gap.size()), 16'h0000, "ticks missing");
  endtask : tick_case

  // sync byte at a bit time of k and a half base clock periods gives k+1 counts
  task ab_case(input logic w, input logic h, input int k);
    int d;
    d = int'(base(w, h, 1'b0));
    wide = w;
    hs = h;
    strobe(5'h01);
    repeat (4) @(negedge mclk_i);
    chk({14'h0000, idle, hold}, 16'h0001, "measure start");
    exp_div.push_back(16'(k + 1));
    node_u.send_byte(d * k + d / 2, 8'h55);
    repeat (8) @(negedge mclk_i);
    chk(16'(exp_div.size()), 16'h0000, "no completion");
    strobe(5'h08);
    repeat (2) @(negedge mclk_i);
    chk({15'h0000, rif}, 16'h0000, "flag after read");
  endtask : ab_case

  // result watcher: takes the oldest note off a queue whenever a result appears
  always @(posedge mclk_i)
  begin
    if (tick === 1'b1)
    begin
      if (exp_gap.size() > 0)
        chk(gap + 16'h0001, exp_gap.pop_front(), "tick period");
      gap = 16'h0000;
      ticks++;
    end
    else
      gap++;
    if (ab_prev === 1'b1 && ab_en === 1'b0 && exp_div.size() > 0)
    begin
      chk(div, exp_div.pop_front(), "measured divisor");
      chk({15'h0000, rif & idle & !hold}, 16'h0001, "completion flags");
    end
    if (wev === 1'b1)
      wakes++;
    ab_prev = ab_en;
  end

  // watchdog: the tests take about 52,000 cycles, the slow sync byte most of them
  initial
  begin
    #(90000 * 20);
    err_count++;
    give_verdict();
  end

  initial
  begin
    seed = 32'h7a4a;
    {nrst_i, en, syncm, slp, wide, hs, stb, clr, dhi, dlo, gap, ab_prev} = '0;
    en = 1'b1;
    repeat (16) @(negedge mclk_i);
    nrst_i = 1'b1;
    chk({8'h00, tick, ab_en, ovf, wakeup_enable, rif, idle, hold, wev}, 16'h0004, "reset");
    chk(div, 16'h0000, "reset divisor");
    for (int i = 0; i < 4; i++)
    begin
      dlo = 8'h01 + 8'($random(seed) & 3);
      dhi = i[1] ? 8'h00 : 8'($random(seed));
      tick_case(i[1], i[0], 1'b0, {dhi, dlo});
    end
    tick_case(1'b0, 1'b1, 1'b1, 16'h0002);
    tick_case(1'b1, 1'b1, 1'b1, 16'h0001);
    $display("test tick periods done");
    do_write(16'h00ff);
    repeat (50) @(negedge mclk_i);
    tick_case(1'b1, 1'b1, 1'b0, 16'h0003);
    slp = 1'b1;
    t0 = ticks;
    repeat (600) @(negedge mclk_i);
    chk(16'(ticks - t0), 16'h0000, "ticks in sleep");
    slp = 1'b0;
    $display("test rewrite and sleep done");
    ab_case(1'b0, 1'b0, 5);
    ab_case(1'b0, 1'b1, 259);
    ab_case(1'b1, 1'b0, 5);
    ab_case(1'b1, 1'b1, 5);
    $display("test measurement done");
    strobe(5'h01);
    repeat (4) @(negedge mclk_i);
    do_write(16'h1234);
    strobe(5'h02);
    repeat (3) @(negedge mclk_i);
    chk({13'h0000, idle, hold, ab_en}, 16'h0004, "abort");
    chk(div, 16'h0006, "write while measuring");
    $display("test abort done");
    strobe(5'h04);
    repeat (3) @(negedge mclk_i);
    chk({14'h0000, wakeup_enable, hold}, 16'h0003, "wake armed");
    t0 = wakes;
    node_u.send_break(64, 13);
    chk(16'(wakes - t0), 16'h0001, "wake pulse");
    chk({14'h0000, wakeup_enable, rif}, 16'h0001, "break end");
    strobe(5'h08);
    repeat (2) @(negedge mclk_i);
    chk({15'h0000, rif}, 16'h0000, "wake flag read");
    strobe(5'h05);
    exp_div.push_back(16'h0006);
    node_u.send_break(22, 13);
    node_u.send_byte(22, 8'h55);
    repeat (8) @(negedge mclk_i);
    chk(16'(exp_div.size()), 16'h0000, "measure after break");
    strobe(5'h08);
    syncm = 1'b1;
    strobe(5'h04);
    repeat (3) @(negedge mclk_i);
    chk({15'h0000, wakeup_enable}, 16'h0000, "wake in sync mode");
    syncm = 1'b0;
    strobe(5'h04);
    // wake cancel order: read data, see idle and armed, then clear wake enable and overflow
    strobe(5'h08);
    chk({14'h0000, idle, wakeup_enable}, 16'h0003, "armed and idle");
    @(negedge mclk_i);
    clr = 2'b11;
    @(negedge mclk_i);
    clr = 2'b00;
    repeat (2) @(negedge mclk_i);
    chk({13'h0000, wakeup_enable, hold, ovf}, 16'h0000, "wake cancel");
    strobe(5'h04);
    t0 = wakes;
    node_u.send_byte(64, 8'h55);
    chk({15'h0000, wakeup_enable}, 16'h0000, "nonzero wake");
    chk(16'(wakes - t0), 16'h0001, "nonzero wake pulse");
    $display("test wake-up done");
    // a disabled port drops back to its reset state
    @(negedge mclk_i);
    en = 1'b0;
    repeat (2) @(negedge mclk_i);
    chk(div, 16'h0000, "divisor when disabled");
    chk({8'h00, tick, ab_en, ovf, wakeup_enable, rif, idle, hold, wev}, 16'h0004, "flags when disabled");
    en = 1'b1;
    $display("test port disable done");
    give_verdict();
  end
endmodule : tb_top
